/* inc/sirpc_defs.svh */
// register map, field positions, reset values and timing counts of the serial control block
`ifndef SIRPC_DEFS_SVH
`define SIRPC_DEFS_SVH
// ==========================================
// register word indices (byte address = 4 * index)
`define SIRPC_IDX_CTRL 2'h0
`define SIRPC_IDX_STAT 2'h1
`define SIRPC_IDX_DATA 2'h2
// ==========================================
// serial_control_reg bit positions
`define SIRPC_C_RXIE 7
`define SIRPC_C_MSTR 5
`define SIRPC_C_CPOL 4
`define SIRPC_C_CPHA 3
`define SIRPC_C_WOM 2
`define SIRPC_C_EN 1
`define SIRPC_C_TXIE 0
// ==========================================
// serial_status_control_reg bit positions
`define SIRPC_S_RXF 7
`define SIRPC_S_ERROR_IRQ_ENABLE 6
`define SIRPC_S_OVR 5
`define SIRPC_S_FLT 4
`define SIRPC_S_TXE 3
`define SIRPC_S_FDEN 2
`define SIRPC_S_BAUD_HI 1
`define SIRPC_S_BAUD_LO 0
// ==========================================
// reset values of the register images
`define SIRPC_CTRL_RST 8'h28
`define SIRPC_STAT_RST 8'h08
// ==========================================
// master serial clock half period limits in bus clocks (half period is limit plus one), per baud select
`define SIRPC_HALF_0 5'h03
`define SIRPC_HALF_1 5'h07
`define SIRPC_HALF_2 5'h0f
`define SIRPC_HALF_3 5'h1f
// last edge index of one byte: eight clock cycles, two edges each
`define SIRPC_LAST_EDGE 4'hf
`endif

/* inc/sirpc_pkg.sv */
// types of the serial control block: engine states and the state record
package sirpc_pkg;
  // ==========================================
  // transfer engine states, one-hot
  typedef enum logic [1:0] {
    SIRPC_IDLE = 2'b01,
    SIRPC_RUN = 2'b10
  } sirpc_state_t;

  // ==========================================
  // every flip-flop of the block
  typedef struct packed {
    logic [7:0] hrdata;
    logic hreadyOut;
    logic apValid;
    logic apWrite;
    logic [1:0] apIdx;
    logic rxIe;
    logic master;
    logic cpol;
    logic cpha;
    logic wom;
    logic enable;
    logic txIe;
    logic rxFull;
    logic error_irq_enable;
    logic overrun;
    logic fault;
    logic txEmpty;
    logic faultDetEn;
    logic [1:0] baud;
    logic rxArm;
    logic ovrArm;
    logic faultArm;
    logic [7:0] txBuf;
    logic [7:0] rxBuf;
    logic [7:0] shift;
    logic sampled;
    logic outBit;
    logic [3:0] edgeCnt;
    logic [4:0] divCnt;
    logic sckPh;
    sirpc_state_t state;
    logic [3:0] syncA;
    logic [3:0] syncB;
    logic sckPrev;
    logic sckOut;
    logic sckOe;
    logic mosiOut;
    logic mosiOe;
    logic misoOut;
    logic misoOe;
    logic pinsOwned;
    logic txIrq;
    logic rxIrq;
    logic errIrq;
  } sirpc_regs_t;
endpackage

/* rtl/sirpc_serial_ctrl.sv */
// serial peripheral control block: registers, flags, interrupts, reset and pin ownership
//
// The implementer's own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`include "sirpc_defs.svh"

// How it works
// [R1] tx request needs empty, tx enable, module enable
// [R2] rx request needs full and rx enable
// [R3] overrun and fault share one error enable
// [R4] status read then data read clears full
// [R5] data write clears tx empty
// [R6] byte into receive register sets full
// [R7] byte into shift register sets empty
// [R8] fault never sets without detect enable
// [R9] reset restores every bit
// [R10] disabled: empty set, abort, pins released
// [R11] disable keeps control bits and flags
// [R12] master fault clears module enable
// [R13] wait: keeps running, requests wake cpu
// [R14] stop freezes engine, registers kept
// [R15] break with clear enable: flags clear normally
// [R16] break without clear enable: flags frozen; here only their clears are blocked, flags still get set
// [R17] break data write ignored without clear enable
// [R18] slave output only when selected
// [R19] enabled block owns pin directions
// [R20] clock out as master, in as slave
// [R21] shift out and sample in together
// [R22] status read then data read clears overrun
// [R23] status read then control write clears fault
// [R24] requests are levels following flags
module sirpc_serial_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic breakActive,
  input wire logic breakClearEnable,
  input wire logic stopMode,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic slaveSelIn_n,
  output logic pinsOwned,
  output logic txIrq,
  output logic rxIrq,
  output logic errIrq
);
  import sirpc_pkg::*;

  // ==========================================
  // state record and its next value
  sirpc_regs_t s_ff; // all flip-flops
  sirpc_regs_t nxt_s; // filled by the one comb process

  // comb helpers
  // all of these get a value on every path of the comb process
  logic apTake; // address phase accepted
  logic rdStat; // status read this cycle
  logic rdData; // data read this cycle
  logic wrCtrl; // control write in data phase
  logic wrStat; // status write in data phase
  logic wrData; // data write in data phase
  logic flagLock; // break protects the flags
  logic sckS; // synchronised serial clock
  logic dinS; // synchronised data in for our mode
  logic selS; // slave select low, synchronised
  logic faultNow; // select pin inconsistent with mode
  logic lead; // leading serial clock edge
  logic trail; // trailing serial clock edge
  logic tick; // master half period elapsed
  logic done; // last trailing edge of a byte
  logic [4:0] half; // master half period limit
  logic [7:0] ctrlImg; // control register image
  logic [7:0] statImg; // status register image

  // ==========================================
  // decode of a word index, used by reads and writes
  function automatic logic hit(input logic [1:0] idx, input logic [1:0] target);
    hit = (idx == target);
  endfunction

  // ==========================================
  // next state
  always_comb begin
    nxt_s = s_ff;
    // bus side
    // an address phase counts only when the bus is ready and the transfer is real
    apTake = hsel & htrans[1] & hready;
    // reads act in the address phase, in step with the read data capture
    rdStat = apTake & ~hwrite & hit(haddr[3:2], `SIRPC_IDX_STAT);
    rdData = apTake & ~hwrite & hit(haddr[3:2], `SIRPC_IDX_DATA);
    // writes act in the data phase, when hwdata stands
    wrCtrl = s_ff.apValid & s_ff.apWrite & hit(s_ff.apIdx, `SIRPC_IDX_CTRL);
    wrStat = s_ff.apValid & s_ff.apWrite & hit(s_ff.apIdx, `SIRPC_IDX_STAT);
    wrData = s_ff.apValid & s_ff.apWrite & hit(s_ff.apIdx, `SIRPC_IDX_DATA);
    flagLock = breakActive & ~breakClearEnable; // R16
    // pins: two flip-flops, only the second stage is looked at
    // stage order is {clock, miso, mosi, select}
    // the sync costs two clocks each way, which sets the fastest usable baud
    sckS = s_ff.syncB[3];
    // a master listens on miso, a slave on mosi
    dinS = s_ff.master ? s_ff.syncB[2] : s_ff.syncB[1]; // R21
    // select is active low at the pin; selS is high while selected
    selS = ~s_ff.syncB[0];
    // mode fault: master sees select low, slave loses select mid-byte
    // gated in stop, where the engine is frozen while the pin sync keeps sampling
    faultNow = s_ff.enable & s_ff.faultDetEn & ~stopMode &
               (s_ff.master ? selS : (~selS & (s_ff.state == SIRPC_RUN))); // R8
    // master baud divider
    // one half period is the limit plus one bus clock
    case (s_ff.baud)
      2'h0: half = `SIRPC_HALF_0;
      2'h1: half = `SIRPC_HALF_1;
      2'h2: half = `SIRPC_HALF_2;
      default: half = `SIRPC_HALF_3;
    endcase
    tick = s_ff.master & (s_ff.state == SIRPC_RUN) & (s_ff.divCnt == half);
    // edges: master from its divider, slave from the sampled pin while selected
    if (s_ff.master) begin
      lead = tick & ~s_ff.sckPh;
      trail = tick & s_ff.sckPh;
    end else begin
      lead = selS & ((sckS ^ s_ff.cpol) & ~(s_ff.sckPrev ^ s_ff.cpol));
      trail = selS & (~(sckS ^ s_ff.cpol) & (s_ff.sckPrev ^ s_ff.cpol)) &
              (s_ff.state == SIRPC_RUN);
    end
    done = trail & (s_ff.edgeCnt == `SIRPC_LAST_EDGE);
    // register images, read back through the address phase mux
    ctrlImg = 8'h00;
    ctrlImg[`SIRPC_C_RXIE] = s_ff.rxIe;
    ctrlImg[`SIRPC_C_MSTR] = s_ff.master;
    ctrlImg[`SIRPC_C_CPOL] = s_ff.cpol;
    ctrlImg[`SIRPC_C_CPHA] = s_ff.cpha;
    ctrlImg[`SIRPC_C_WOM] = s_ff.wom;
    ctrlImg[`SIRPC_C_EN] = s_ff.enable;
    ctrlImg[`SIRPC_C_TXIE] = s_ff.txIe;
    statImg = 8'h00;
    statImg[`SIRPC_S_RXF] = s_ff.rxFull;
    statImg[`SIRPC_S_ERROR_IRQ_ENABLE] = s_ff.error_irq_enable;
    statImg[`SIRPC_S_OVR] = s_ff.overrun;
    statImg[`SIRPC_S_FLT] = s_ff.fault;
    statImg[`SIRPC_S_TXE] = s_ff.txEmpty;
    statImg[`SIRPC_S_FDEN] = s_ff.faultDetEn;
    statImg[`SIRPC_S_BAUD_HI:`SIRPC_S_BAUD_LO] = s_ff.baud;

    // pins enter the block here and nowhere else
    nxt_s.syncA = {sckIn, misoIn, mosiIn, slaveSelIn_n};
    nxt_s.syncB = s_ff.syncA;
    nxt_s.sckPrev = sckS;

    // address phase capture, read data registered for the data phase
    nxt_s.hreadyOut = 1'b1;
    // no wait states: the answer always comes in the very next cycle
    nxt_s.apValid = apTake;
    nxt_s.apWrite = hwrite;
    nxt_s.apIdx = haddr[3:2];
    if (apTake & ~hwrite) begin
      case (haddr[3:2])
        `SIRPC_IDX_CTRL: nxt_s.hrdata = ctrlImg;
        `SIRPC_IDX_STAT: nxt_s.hrdata = statImg;
        `SIRPC_IDX_DATA: nxt_s.hrdata = s_ff.rxBuf;
        default: nxt_s.hrdata = 8'h00; // unmapped reads as zero
      endcase
    end

    // control and config writes; disabling keeps these bits
    if (wrCtrl) begin
      nxt_s.rxIe = hwdata[`SIRPC_C_RXIE];
      nxt_s.master = hwdata[`SIRPC_C_MSTR];
      nxt_s.cpol = hwdata[`SIRPC_C_CPOL];
      nxt_s.cpha = hwdata[`SIRPC_C_CPHA];
      nxt_s.wom = hwdata[`SIRPC_C_WOM];
      nxt_s.enable = hwdata[`SIRPC_C_EN];
      nxt_s.txIe = hwdata[`SIRPC_C_TXIE];
    end
    if (wrStat) begin
      nxt_s.error_irq_enable = hwdata[`SIRPC_S_ERROR_IRQ_ENABLE];
      nxt_s.faultDetEn = hwdata[`SIRPC_S_FDEN];
      nxt_s.baud = hwdata[`SIRPC_S_BAUD_HI:`SIRPC_S_BAUD_LO];
    end

    // first step of the two-step clears; a locked break leaves arms untouched
    if (rdStat & ~flagLock) begin // R15
      nxt_s.rxArm = s_ff.rxFull;
      nxt_s.ovrArm = s_ff.overrun;
      nxt_s.faultArm = s_ff.fault;
    end
    // second steps
    // an arm left clear means the flag was not set when status was read
    if (rdData & ~flagLock) begin
      if (s_ff.rxArm) begin
        nxt_s.rxFull = 1'b0; // R4
      end
      if (s_ff.ovrArm) begin
        nxt_s.overrun = 1'b0; // R22
      end
      nxt_s.rxArm = 1'b0;
      nxt_s.ovrArm = 1'b0;
    end
    if (wrCtrl & ~flagLock & s_ff.faultArm & ~faultNow) begin
      nxt_s.fault = 1'b0; // R23
      nxt_s.faultArm = 1'b0;
    end
    if (faultNow) begin
      nxt_s.faultArm = 1'b0; // a fault meanwhile spoils the clear
    end
    // data write: a locked break swallows it
    if (wrData & ~flagLock) begin // R17
      nxt_s.txBuf = hwdata[7:0];
      nxt_s.txEmpty = 1'b0; // R5
    end

    // transfer engine; frozen in stop, registers kept
    if (~stopMode) begin // R14
      nxt_s.divCnt = tick ? 5'h00 : 5'(s_ff.divCnt + 5'h01);
      case (s_ff.state)
        SIRPC_IDLE: begin
          // a fresh byte always starts counting from its first edge
          nxt_s.edgeCnt = 4'h0;
          nxt_s.sckPh = 1'b0;
          // buffer to shifter; not in a cycle that writes the buffer
          if (s_ff.enable & ~s_ff.txEmpty & ~wrData) begin
            nxt_s.shift = s_ff.txBuf;
            // the first bit is on the line before the first edge
            nxt_s.outBit = s_ff.txBuf[7];
            nxt_s.txEmpty = 1'b1; // R7
            // a master starts with the byte it has just taken, zero bytes too
            if (s_ff.master) begin
              nxt_s.state = SIRPC_RUN;
              nxt_s.divCnt = 5'h00;
            end
          end
          // slave starts on select, or on its first edge when cpha is set
          if (s_ff.enable & ~s_ff.master & selS & (~s_ff.cpha | lead)) begin
            nxt_s.state = SIRPC_RUN;
            // the edge that starts the byte is already one of its sixteen
            nxt_s.edgeCnt = {3'h0, lead};
          end
        end
        SIRPC_RUN: begin
          // the master clock phase flips every half period
          if (tick) begin
            nxt_s.sckPh = ~s_ff.sckPh; // R20
          end
          if (lead) begin
            if (~s_ff.cpha) begin
              nxt_s.sampled = dinS; // R21
            end else begin
              nxt_s.outBit = s_ff.shift[7];
            end
          end
          if (trail) begin
            nxt_s.edgeCnt = 4'(s_ff.edgeCnt + 4'h1);
            if (~s_ff.cpha) begin
              nxt_s.shift = {s_ff.shift[6:0], s_ff.sampled};
              nxt_s.outBit = s_ff.shift[6];
            end else begin
              nxt_s.shift = {s_ff.shift[6:0], dinS};
            end
          end
          // both edges are counted; sixteen make one byte
          if (lead) begin
            nxt_s.edgeCnt = 4'(s_ff.edgeCnt + 4'h1);
          end
          if (done) begin
            nxt_s.state = SIRPC_IDLE;
            // with cpha set the last bit stays on the line: the far side samples it on this edge
            nxt_s.shift = 8'h00;
            if (s_ff.rxFull & ~(rdData & ~flagLock & s_ff.rxArm)) begin
              nxt_s.overrun = 1'b1; // byte lost, old one kept
            end else if (~s_ff.overrun) begin
              nxt_s.rxBuf = s_ff.cpha ? {s_ff.shift[6:0], dinS} :
                            {s_ff.shift[6:0], s_ff.sampled};
              nxt_s.rxFull = 1'b1; // R6
            end
          end
          // slave deselected: stop listening to the clock at once
          if (~s_ff.master & ~selS) begin
            nxt_s.state = SIRPC_IDLE;
            nxt_s.edgeCnt = 4'h0;
          end
        end
        default: nxt_s.state = SIRPC_IDLE;
      endcase
    end

    // fault: set wins over any clear in the same cycle
    if (faultNow) begin
      nxt_s.fault = 1'b1; // R8
      if (s_ff.master) begin
        nxt_s.enable = 1'b0; // R12
      end
    end

    // partial reset while disabled; txEmpty is set, other flags and control bits are left alone
    // uses the next enable, so a fault that drops it resets the engine at once
    if (~nxt_s.enable) begin // R11
      nxt_s.txEmpty = 1'b1; // R10
      nxt_s.state = SIRPC_IDLE;
      nxt_s.shift = 8'h00;
      nxt_s.edgeCnt = 4'h0;
      nxt_s.sckPh = 1'b0;
      nxt_s.outBit = 1'b0;
    end

    // pin ownership and drive, registered
    nxt_s.pinsOwned = nxt_s.enable; // R19
    nxt_s.sckOut = nxt_s.cpol ^ nxt_s.sckPh;
    nxt_s.mosiOut = nxt_s.outBit;
    // mosi and miso carry the same bit; only one of them is ever enabled
    nxt_s.misoOut = nxt_s.outBit;
    // wired-or: only a low is driven, the pullup makes the high
    nxt_s.sckOe = nxt_s.enable & nxt_s.master &
                  (~nxt_s.wom | ~nxt_s.sckOut); // R20
    nxt_s.mosiOe = nxt_s.enable & nxt_s.master & (~nxt_s.wom | ~nxt_s.mosiOut);
    nxt_s.misoOe = nxt_s.enable & ~nxt_s.master & selS &
                   (~nxt_s.wom | ~nxt_s.misoOut); // R18

    // level requests; they also wake the cpu from wait
    // a request drops with its flag, so there is no separate acknowledge
    nxt_s.txIrq = nxt_s.txEmpty & nxt_s.txIe & nxt_s.enable; // R1
    nxt_s.rxIrq = nxt_s.rxFull & nxt_s.rxIe; // R2
    nxt_s.errIrq = nxt_s.error_irq_enable & (nxt_s.overrun | nxt_s.fault); // R3
  end

  // ==========================================
  // one register for everything; reset restores all of it
  always_ff @(posedge clk) begin
    if (!reset_n) begin // R9
      s_ff <= '0;
      s_ff.hreadyOut <= 1'b1;
      // only the bits that reset to one need a line of their own
      s_ff.master <= 1'(`SIRPC_CTRL_RST >> `SIRPC_C_MSTR);
      s_ff.cpha <= 1'(`SIRPC_CTRL_RST >> `SIRPC_C_CPHA);
      s_ff.txEmpty <= 1'(`SIRPC_STAT_RST >> `SIRPC_S_TXE);
      s_ff.state <= SIRPC_IDLE;
      // select idles high at the pin, so the sync starts deselected
      s_ff.syncA <= 4'h1;
      s_ff.syncB <= 4'h1;
    end else begin
      s_ff <= nxt_s; // R13
    end
  end

  // ==========================================
  // outputs straight from flip-flops, hresp tied low
  assign hreadyout = s_ff.hreadyOut;
  assign hrdata = {24'h000000, s_ff.hrdata};
  assign hresp = 1'b0;
  assign sckOut = s_ff.sckOut;
  assign sckOe = s_ff.sckOe;
  assign mosiOut = s_ff.mosiOut;
  assign mosiOe = s_ff.mosiOe;
  assign misoOut = s_ff.misoOut;
  assign misoOe = s_ff.misoOe;
  assign pinsOwned = s_ff.pinsOwned; // R19
  assign txIrq = s_ff.txIrq;
  assign rxIrq = s_ff.rxIrq;
  assign errIrq = s_ff.errIrq;
endmodule

/* test/sirpc_serial_ctrl_sva.sv */
// port-level checker of the serial control block, bound to its top module
`timescale 1ns/1ps
module sirpc_serial_ctrl_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic slaveSelIn_n,
  input wire logic sckOe,
  input wire logic mosiOe,
  input wire logic misoOe,
  input wire logic pinsOwned,
  input wire logic txIrq,
  input wire logic rxIrq,
  input wire logic errIrq
);
  // ==========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // reset must quiet every request and the pin ownership, so it is not disabled by reset
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n |=> !txIrq && !rxIrq && !errIrq && !pinsOwned) else $error("outputs active after reset");
  a_tx_gate: assert property (!pinsOwned |-> !txIrq) else $error("tx request while disabled");
  a_oe_owned: assert property ((sckOe || mosiOe || misoOe) |-> pinsOwned) else $error("pin driven while released");
  a_miso_desel: assert property (slaveSelIn_n [*6] |-> !misoOe) else $error("miso driven while deselected");
  a_role_excl: assert property (!(sckOe && misoOe)) else $error("clock and miso driven together");
  a_mosi_miso: assert property (!(mosiOe && misoOe)) else $error("mosi and miso driven together");
  a_bus_ready: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  a_rd_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  // ==========================================
  // main scenarios
  c_tx: cover property (txIrq);
  c_rx: cover property ($rose(rxIrq));
  c_err: cover property ($rose(errIrq));
endmodule
bind sirpc_serial_ctrl sirpc_serial_ctrl_sva i_sva (
  .clk(clk),
  .reset_n(reset_n),
  .hreadyout(hreadyout),
  .hrdata(hrdata),
  .hresp(hresp),
  .slaveSelIn_n(slaveSelIn_n),
  .sckOe(sckOe),
  .mosiOe(mosiOe),
  .misoOe(misoOe),
  .pinsOwned(pinsOwned),
  .txIrq(txIrq),
  .rxIrq(rxIrq),
  .errIrq(errIrq)
);

/* test/sirpc_slave_model.sv */
// behavioural far-side slave: shifts on leading, samples on trailing clock edge
`timescale 1ns/1ps
module sirpc_slave_model (
  input wire logic sck,
  input wire logic mosi,
  input wire logic sel_n,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [3:0] cnt; // bit count, its low three bits index the bit and wrap every byte
  initial begin
    cnt = 4'h0;
    miso = 1'b0;
    rxByte = 8'h00;
  end
  // ==========================================
  // framing: select restarts the byte, release scrambles miso
  always @(negedge sel_n) cnt = 4'h0;
  // released line is no longer held at the last bit
  always @(posedge sel_n) miso = ~miso;
  // ==========================================
  // msb first, one bit per clock cycle, eight cycles per byte
  always @(posedge sck) begin
    if (!sel_n) miso = txByte[3'h7 - cnt[2:0]];
  end
  always @(negedge sck) begin
    if (!sel_n) begin
      rxByte = {rxByte[6:0], mosi};
      cnt = cnt + 4'h1;
    end
  end
endmodule

/* test/tb.sv */
// self-checking bench of the serial control block with a slave model
`timescale 1ns/1ps
`include "sirpc_defs.svh"
module tb;
  logic clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic breakActive = 1'b0, slaveSelIn_n = 1'b1, modelSel_n = 1'b1;
  logic sckB = 1'b0, mosiB = 1'b0;
  logic breakClr = 1'b0, stopMode = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [7:0] mTx = 8'hc3, q;
  logic hreadyout, hresp, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe;
  logic pinsOwned, txIrq, rxIrq, errIrq, mMiso;
  logic [31:0] hrdata;
  logic [7:0] mRx;
  int errors = 0, samples_checked = 0;
  // pin wires: whoever enables drives
  wire logic sckW = sckOe ? sckOut : sckB;
  wire logic mosiW = mosiOe ? mosiOut : mosiB;
  wire logic misoW = misoOe ? misoOut : mMiso;
  always #2.5 clk = ~clk;
  sirpc_serial_ctrl i_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .breakActive(breakActive),
    .breakClearEnable(breakClr), .stopMode(stopMode), .sckIn(sckW), .sckOut(sckOut), .sckOe(sckOe),
    .mosiIn(mosiW), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoW), .misoOut(misoOut),
    .misoOe(misoOe), .slaveSelIn_n(slaveSelIn_n), .pinsOwned(pinsOwned), .txIrq(txIrq),
    .rxIrq(rxIrq), .errIrq(errIrq));
  sirpc_slave_model i_slave (.sck(sckW), .mosi(mosiW), .sel_n(modelSel_n), .txByte(mTx),
    .miso(mMiso), .rxByte(mRx));
  // ==========================================
  // helpers
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
      errors++;
    end
  endtask
  // bounded wait: 0 bus ready, 1 rx request, 2 error request
  task automatic waitSig(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((k == 0 ? hreadyout : k == 1 ? rxIrq : errIrq) !== 1'b1 && n < 2000);
    if (n >= 2000) begin
      $display("CHECK FAILED wait %0d exp 1 got 0", k);
      errors++;
      stop_test();
    end
  endtask
  task automatic bus(input logic w, input logic [1:0] ix, input logic [7:0] d);
    haddr <= {28'h0, ix, 2'b00};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    waitSig(0);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitSig(0);
    q = hrdata[7:0];
  endtask
  // idle cycle after a write so a following read sees the new value
  task automatic wr(input logic [1:0] ix, input logic [7:0] d);
    bus(1'b1, ix, d);
    @(posedge clk);
  endtask
  task automatic rdc(input string s, input logic [1:0] ix, input logic [7:0] e);
    bus(1'b0, ix, 8'h00);
    chk(s, e, q);
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    rdc("ctrl", `SIRPC_IDX_CTRL, `SIRPC_CTRL_RST);
    rdc("stat", `SIRPC_IDX_STAT, `SIRPC_STAT_RST);
    $display("test reset done");
  endtask
  task t_master;
    modelSel_n <= 1'b0;
    wr(`SIRPC_IDX_CTRL, 8'hab);
    repeat (3) @(posedge clk);
    chk("txIrq", 1'b1, txIrq);
    wr(`SIRPC_IDX_DATA, 8'ha5);
    waitSig(1);
    chk("slave rx", 8'ha5, mRx);
    rdc("stat full", `SIRPC_IDX_STAT, 8'h88);
    rdc("data", `SIRPC_IDX_DATA, 8'hc3);
    rdc("stat clr", `SIRPC_IDX_STAT, 8'h08);
    chk("rxIrq", 1'b0, rxIrq);
    $display("test master done");
  endtask
  task t_overrun;
    wr(`SIRPC_IDX_STAT, 8'h40);
    mTx <= 8'h5a;
    wr(`SIRPC_IDX_DATA, 8'h11);
    waitSig(1);
    mTx <= 8'h3c;
    wr(`SIRPC_IDX_DATA, 8'h22);
    waitSig(2);
    rdc("stat ovr", `SIRPC_IDX_STAT, 8'he8);
    rdc("data kept", `SIRPC_IDX_DATA, 8'h5a);
    rdc("stat clr", `SIRPC_IDX_STAT, 8'h48);
    chk("errIrq", 1'b0, errIrq);
    $display("test overrun done");
  endtask
  task t_fault;
    slaveSelIn_n <= 1'b0;
    repeat (20) @(posedge clk);
    slaveSelIn_n <= 1'b1;
    rdc("stat nodet", `SIRPC_IDX_STAT, 8'h48);
    wr(`SIRPC_IDX_STAT, 8'h44);
    slaveSelIn_n <= 1'b0;
    waitSig(2);
    repeat (3) @(posedge clk);
    chk("pinsOwned", 1'b0, pinsOwned);
    slaveSelIn_n <= 1'b1;
    rdc("ctrl", `SIRPC_IDX_CTRL, 8'ha9);
    rdc("stat flt", `SIRPC_IDX_STAT, 8'h5c);
    wr(`SIRPC_IDX_CTRL, 8'ha9);
    rdc("stat clr", `SIRPC_IDX_STAT, 8'h4c);
    chk("errIrq", 1'b0, errIrq);
    $display("test fault done");
  endtask
  task t_break;
    wr(`SIRPC_IDX_CTRL, 8'hab);
    breakActive <= 1'b1;
    wr(`SIRPC_IDX_DATA, 8'h77);
    repeat (100) @(posedge clk);
    chk("slave rx", 8'h22, mRx);
    chk("txIrq", 1'b1, txIrq);
    // clear enable set: the write lands and the flags clear within the break
    breakClr <= 1'b1;
    wr(`SIRPC_IDX_DATA, 8'h77);
    waitSig(1);
    chk("slave rx brk", 8'h77, mRx);
    rdc("stat brk", `SIRPC_IDX_STAT, 8'hcc);
    rdc("data brk", `SIRPC_IDX_DATA, 8'h3c);
    breakActive <= 1'b0;
    breakClr <= 1'b0;
    rdc("stat after brk", `SIRPC_IDX_STAT, 8'h4c);
    // stop freezes the engine: the byte waits in the buffer until stop ends
    stopMode <= 1'b1;
    wr(`SIRPC_IDX_DATA, 8'h5a);
    repeat (50) @(posedge clk);
    rdc("stat stop", `SIRPC_IDX_STAT, 8'h44);
    chk("slave rx stop", 8'h77, mRx);
    stopMode <= 1'b0;
    waitSig(1);
    chk("slave rx resume", 8'h5a, mRx);
    rdc("stat resume", `SIRPC_IDX_STAT, 8'hcc);
    rdc("data resume", `SIRPC_IDX_DATA, 8'h3c);
    $display("test break done");
  endtask
  // bench acts as master, link clock period 125 ns
  task t_slave;
    logic [7:0] b;
    b = 8'h96;
    modelSel_n <= 1'b1;
    wr(`SIRPC_IDX_CTRL, 8'h8a);
    slaveSelIn_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("misoOe", 1'b1, misoOe);
    chk("sckOe", 1'b0, sckOe);
    for (int i = 7; i >= 0; i--) begin
      repeat (12) @(posedge clk);
      sckB <= 1'b1;
      mosiB <= b[i];
      repeat (13) @(posedge clk);
      sckB <= 1'b0;
    end
    waitSig(1);
    bus(1'b0, `SIRPC_IDX_STAT, 8'h00);
    chk("stat full", 8'h80, q & 8'h80);
    rdc("data", `SIRPC_IDX_DATA, b);
    slaveSelIn_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("misoOe", 1'b0, misoOe);
    wr(`SIRPC_IDX_CTRL, 8'h08);
    chk("pinsOwned", 1'b0, pinsOwned);
    rdc("ctrl", `SIRPC_IDX_CTRL, 8'h08);
    $display("test slave done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_master();
    t_overrun();
    t_fault();
    t_break();
    t_slave();
    stop_test();
  end
endmodule
